// ===== common/nvh_pkg.sv
// Purpose: constants and carrier types for the nonvolatile memory host
// Assumes: 100 MHz clk, fast or slow speed grade chosen by parameter
// Notes: times kept in their own units, cycle counts derived
package nvh_pkg;
    localparam int CLK_MHZ = 100;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;

    // times in the unit each name gives (ns pairs: fast grade, slow grade)
    localparam int T_ACE_FAST_NS = 25;
    localparam int T_ACE_SLOW_NS = 45;
    localparam int T_DOE_FAST_NS = 12;
    localparam int T_DOE_SLOW_NS = 20;
    localparam int T_SCE_FAST_NS = 20;
    localparam int T_SCE_SLOW_NS = 30;
    localparam int T_SD_FAST_NS = 10;
    localparam int T_SD_SLOW_NS = 15;
    localparam int STORE_REQUEST_PULSE_WIDTH_NS = 15;
    localparam int T_STORE_MS = 8;
    localparam int T_SS_US = 500;
    localparam int T_RECALL_US = 600;
    localparam int POWERUP_RECALL_DURATION_MS = 30;
    localparam int T_SLEEP_MS = 8;
    localparam int T_WAKE_MS = 30;

    // least times round up
    function automatic int ns_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int ACE_FAST_CYC = ns_cyc(T_ACE_FAST_NS);
    localparam int ACE_SLOW_CYC = ns_cyc(T_ACE_SLOW_NS);
    localparam int SCE_FAST_CYC = ns_cyc(T_SCE_FAST_NS);
    localparam int SCE_SLOW_CYC = ns_cyc(T_SCE_SLOW_NS);
    localparam int PHSB_CYC = ns_cyc(STORE_REQUEST_PULSE_WIDTH_NS);
    localparam int STORE_CYC = T_STORE_MS * CLK_MHZ * 1000;
    localparam int SS_CYC = T_SS_US * CLK_MHZ;
    localparam int RECALL_CYC = (T_SS_US + T_RECALL_US) * CLK_MHZ;
    localparam int HRECALL_CYC = POWERUP_RECALL_DURATION_MS * CLK_MHZ * 1000;
    localparam int SLEEP_CYC = T_SLEEP_MS * CLK_MHZ * 1000;
    localparam int WAKE_CYC = T_WAKE_MS * CLK_MHZ * 1000;
    localparam int CMD_LEN = 6;

    typedef enum logic [2:0] {
        NVH_OP_READ, NVH_OP_WRITE, NVH_OP_SOFT, NVH_OP_HWSTORE,
        NVH_OP_SLEEP, NVH_OP_WAKE
    } nvh_op_type;

    typedef struct packed {
        nvh_op_type op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] lanes;
        logic clock_reg;
        logic [ADDR_W*CMD_LEN-1:0] cmd_addrs;
        logic long_wait;
    } nvh_req_type;

    typedef struct packed {
        logic chip_enable_first_n;
        logic chip_enable_second;
        logic write_n;
        logic output_enable_n;
        logic low_byte_enable_n;
        logic high_byte_enable_n;
        logic [ADDR_W-1:0] addr;
    } nvh_pins_type;
endpackage

// ===== core/nvh_host.sv
// Purpose: host controller driving the memory's asynchronous pins
// Assumes: one request at a time, pins sampled on clk
// Notes: completion of long operations is timed, not sensed
module nvh_host import nvh_pkg::*; #(
    parameter bit SLOW_GRADE = 1'b0,
    parameter int STORE_CYCLES = STORE_CYC,
    parameter int RECALL_CYCLES = RECALL_CYC,
    parameter int POWERUP_CYCLES = HRECALL_CYC,
    parameter int SLEEP_CYCLES = SLEEP_CYC,
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire nvh_req_type req,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output nvh_pins_type pins,
    output logic hw_store_request_n,
    output logic sleep_request_n,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_POWERUP, ST_IDLE, ST_SETUP, ST_ACTIVE, ST_GAP, ST_HWPULSE,
        ST_WAIT, ST_SLEEPING
    } nvh_st_type;

    localparam int CW = 32;
    localparam int ACC_CYC = SLOW_GRADE ? ACE_SLOW_CYC : ACE_FAST_CYC;
    localparam int WR_CYC = SLOW_GRADE ? SCE_SLOW_CYC : SCE_FAST_CYC;

    nvh_st_type st_r, st_nxt;
    logic [CW-1:0] cnt_r;
    logic [2:0] idx_r;
    nvh_req_type cur_r;
    logic sel_r, we_r, oe_r;
    logic [DATA_W-1:0] rdata_r;
    logic rsp_r, hw_r, zz_r, doe_r;

    wire is_wr = cur_r.op == NVH_OP_WRITE;
    wire is_soft = cur_r.op == NVH_OP_SOFT;
    wire cnt_done = cnt_r == '0;
    wire last_cmd = idx_r == 3'(CMD_LEN - 1);
    wire [ADDR_W-1:0] soft_addr =
        cur_r.cmd_addrs[idx_r*ADDR_W +: ADDR_W];
    wire [CW-1:0] active_len = CW'(is_wr ? WR_CYC : ACC_CYC);
    wire [CW-1:0] soft_wait =
        CW'(cur_r.long_wait ? RECALL_CYCLES : SS_CYC);

    assign req_ready = st_r == ST_IDLE;
    assign rsp_valid = rsp_r;
    assign rsp_rdata = rdata_r;
    assign hw_store_request_n = hw_r;
    assign sleep_request_n = zz_r;
    assign dq_out = cur_r.wdata;
    assign dq_oe = doe_r;

    // ----------------------------------------------------------------
    // pin assembly
    // ----------------------------------------------------------------
    // select pair low/high
    assign pins.chip_enable_first_n = ~sel_r;
    assign pins.chip_enable_second = sel_r;
    assign pins.write_n = ~we_r;
    assign pins.output_enable_n = ~oe_r;
    // clock writes force the low lane only, enabled for the whole operation
    assign pins.low_byte_enable_n =
        (st_r == ST_IDLE || st_r == ST_SLEEPING || st_r == ST_POWERUP) ?
        1'b1 : ~(cur_r.lanes[0] | cur_r.clock_reg | is_soft);
    assign pins.high_byte_enable_n =
        (st_r == ST_IDLE || st_r == ST_SLEEPING || st_r == ST_POWERUP) ?
        1'b1 : ~(cur_r.lanes[1] | is_soft);
    assign pins.addr = is_soft ? soft_addr : cur_r.addr;

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_POWERUP: if (cnt_done) st_nxt = ST_IDLE;
            ST_IDLE: if (req_valid) begin
                unique case (req.op)
                    NVH_OP_HWSTORE: st_nxt = ST_HWPULSE;
                    NVH_OP_SLEEP: st_nxt = ST_WAIT;
                    NVH_OP_WAKE: st_nxt = ST_IDLE;
                    default: st_nxt = ST_SETUP;
                endcase
            end
            ST_SETUP: st_nxt = ST_ACTIVE;
            ST_ACTIVE: if (cnt_done) st_nxt = ST_GAP;
            ST_GAP: st_nxt = (is_soft && !last_cmd) ? ST_SETUP :
                             is_soft ? ST_WAIT : ST_IDLE;
            ST_HWPULSE: if (cnt_done) st_nxt = ST_WAIT;
            ST_WAIT: if (cnt_done) st_nxt =
                (cur_r.op == NVH_OP_SLEEP) ? ST_SLEEPING : ST_IDLE;
            ST_SLEEPING: if (req_valid && req.op == NVH_OP_WAKE)
                st_nxt = ST_WAIT;
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_POWERUP;
            // recall wait loaded here, so every release waits
            cnt_r <= CW'(POWERUP_CYCLES);
            idx_r <= '0;
            cur_r <= '0;
            sel_r <= 1'b0;
            we_r <= 1'b0;
            oe_r <= 1'b0;
            rdata_r <= '0;
            rsp_r <= 1'b0;
            hw_r <= 1'b1;
            zz_r <= 1'b1;
            doe_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            rsp_r <= 1'b0;
            if (!cnt_done) cnt_r <= cnt_r - 1'b1;
            unique case (st_r)
                ST_IDLE: if (req_valid) begin
                    cur_r <= req;
                    idx_r <= '0;
                    if (req.op == NVH_OP_HWSTORE) begin
                        hw_r <= 1'b0;
                        cnt_r <= CW'(PHSB_CYC);
                    end
                    if (req.op == NVH_OP_SLEEP) begin
                        zz_r <= 1'b0;
                        cnt_r <= CW'(SLEEP_CYCLES);
                    end
                    if (req.op == NVH_OP_WAKE) rsp_r <= 1'b1;
                end
                ST_SETUP: begin
                    sel_r <= 1'b1;
                    we_r <= is_wr;
                    oe_r <= !is_wr;
                    doe_r <= is_wr;
                    cnt_r <= active_len - 1'b1;
                end
                ST_ACTIVE: if (cnt_done) begin
                    sel_r <= 1'b0;
                    we_r <= 1'b0;
                    oe_r <= 1'b0;
                    if (!is_wr && !is_soft) rdata_r <= dq_in;
                end
                ST_GAP: begin
                    doe_r <= 1'b0;
                    if (is_soft && !last_cmd) idx_r <= idx_r + 1'b1;
                    if (is_soft && last_cmd) cnt_r <= soft_wait;
                    if (!is_soft) rsp_r <= 1'b1;
                end
                ST_HWPULSE: if (cnt_done) begin
                    // store line high before any access
                    hw_r <= 1'b1;
                    cnt_r <= CW'(STORE_CYCLES);
                end
                ST_WAIT: if (cnt_done) rsp_r <= cur_r.op != NVH_OP_SLEEP;
                ST_SLEEPING: if (req_valid && req.op == NVH_OP_WAKE) begin
                    zz_r <= 1'b1;
                    cur_r <= req;
                    cnt_r <= CW'(WAKE_CYCLES);
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_read_strobe_high: assert property (@(posedge clk) disable iff (!rst_n)
        oe_r |-> !we_r) else $error("strobe low in read");
    a_store_line_idle: assert property (@(posedge clk) disable iff (!rst_n)
        sel_r |-> hw_r) else $error("store request in cycle");
    a_addr_stable: assert property (@(posedge clk) disable iff (!rst_n)
        (sel_r && $past(sel_r)) |-> $stable(pins.addr))
        else $error("address moved while selected");
    a_dual_select: assert property (@(posedge clk) disable iff (!rst_n)
        pins.chip_enable_first_n == !pins.chip_enable_second)
        else $error("enable pair inconsistent");
    a_clock_lane: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == ST_SETUP && cur_r.clock_reg && is_wr)
        |=> pins.low_byte_enable_n == 1'b0 && $past(!pins.low_byte_enable_n))
        else $error("low lane late for clock write");
    sequence s_wr_open;
        $rose(we_r) ##0 sel_r;
    endsequence
    a_write_hold: assert property (@(posedge clk) disable iff (!rst_n)
        s_wr_open |-> sel_r [*2])
        else $error("write enable too short");
    a_store_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(hw_r) |-> !hw_r [*2])
        else $error("store pulse too short");
    a_soft_reads: assert property (@(posedge clk) disable iff (!rst_n)
        (sel_r && is_soft) |-> oe_r && !we_r)
        else $error("soft command not a read");
    a_sleep_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !zz_r |-> !sel_r && !doe_r)
        else $error("access while sleeping");
endmodule

// ===== tb/nvh_mem_model.sv
// Purpose: behavioural memory device on the host's far side
// Assumes: 16 words decoded, pins sampled on clk
// Notes: undriven data shows inverse of last value
module nvh_mem_model import nvh_pkg::*; #(
    parameter int BUSY_CYC = 20
) (
    input wire logic clk,
    input wire nvh_pins_type pins,
    input wire logic hw_store_request_n,
    input wire logic sleep_request_n,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    output logic [DATA_W-1:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem_r [16];
    logic [DATA_W-1:0] last_r = '0;
    logic written_r = 1'b0;
    logic hs_d_r = 1'b1;
    int busy_r = 0;
    wire sel = !pins.chip_enable_first_n && pins.chip_enable_second;
    wire live = sel && busy_r == 0 && sleep_request_n;
    // data at once, off while writing
    wire drive = live && pins.write_n && !pins.output_enable_n;
    assign dq_in = drive ? mem_r[pins.addr[3:0]] : ~last_r;
    always @(posedge clk) begin
        last_r <= dq_in;
        hs_d_r <= hw_store_request_n;
        if (busy_r != 0) begin
            busy_r <= busy_r - 1;
        end
        // store only after a write, lock at once
        if (hs_d_r && !hw_store_request_n && written_r) begin
            busy_r <= BUSY_CYC;
            written_r <= 1'b0;
        end
        if (live && !pins.write_n && dq_oe) begin
            written_r <= 1'b1;
            if (!pins.low_byte_enable_n) begin
                mem_r[pins.addr[3:0]][7:0] <= dq_out[7:0];
            end
            if (!pins.high_byte_enable_n) begin
                mem_r[pins.addr[3:0]][15:8] <= dq_out[15:8];
            end
        end
    end
endmodule

// ===== tb/nvsram_async_host_interface_tb_top.sv
// Purpose: self-checking bench for the memory host
// Assumes: long counts shortened to 20 cycles
// Notes: soft sequence without long wait still waits its full fixed time
module nvsram_async_host_interface_tb_top import nvh_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SHORT = 20;
    localparam int SOFT_LO = CMD_LEN * ACE_FAST_CYC;
    localparam int SOFT_HI = CMD_LEN * (ACE_FAST_CYC + 2) + 1;
    logic creg = 1'b0, lw = 1'b1;
    logic [23:0] alog = '0;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    nvh_req_type req = '0;
    logic req_ready, rsp_valid, hsn, sln, dq_oe, sel_d = 1'b0;
    logic [DATA_W-1:0] rsp_rdata, dq_out, dq_in;
    nvh_pins_type pins;
    int mismatches = 0, tests_run = 0, cyc = 0, n = 0;
    int sel_cnt = 0, wr_cyc = 0, hs_cyc = 0, s0 = 0, w0 = 0, rdy_lo = 0;
    wire sel = !pins.chip_enable_first_n && pins.chip_enable_second;
    nvh_host #(.STORE_CYCLES(SHORT), .RECALL_CYCLES(SHORT),
        .POWERUP_CYCLES(SHORT), .SLEEP_CYCLES(SHORT),
        .WAKE_CYCLES(SHORT)) nvh_host_inst (.clk(clk), .rst_n(rst_n),
        .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins),
        .hw_store_request_n(hsn), .sleep_request_n(sln),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    nvh_mem_model nvh_mem_model_inst (.clk(clk), .pins(pins),
        .hw_store_request_n(hsn), .sleep_request_n(sln),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    always #5 clk = ~clk;
    // cycle monitor; ceiling covers the fixed soft wait
    always @(posedge clk) begin
        cyc++;
        sel_d <= sel;
        if (sel && !sel_d) begin
            sel_cnt++;
            alog <= {alog[19:0], pins.addr[3:0]};
        end
        if (!req_ready) rdy_lo++;
        if (sel && !pins.write_n) wr_cyc++;
        if (!hsn) hs_cyc++;
        if (cyc >= 80000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk_w(input string nm, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_n(input string nm, input int lo, hi, g);
        tests_run++;
        if (g < lo || g > hi) begin
            mismatches++;
            $display("mismatch %s exp %0d..%0d got %0d", nm, lo, hi, g);
        end
    endtask
    task automatic do_op(input nvh_op_type op, input logic [3:0] a,
        input logic [15:0] d, input logic [1:0] ln, input int lim);
        @(negedge clk);
        // wake is taken while ready stays low
        while (op != NVH_OP_WAKE && req_ready !== 1'b1) @(negedge clk);
        req.op = op;
        req.addr = {16'h0000, a};
        req.wdata = d;
        req.lanes = ln;
        req.clock_reg = creg;
        req.long_wait = lw;
        req.cmd_addrs = {20'h00e3d, 20'h00e3c, 20'h00e3b,
            20'h00e3a, 20'h00e39, 20'h00e38};
        req_valid = 1'b1;
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (n < lim && rsp_valid !== 1'b1) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_boot();
        repeat (3) @(negedge clk);
        chk_w("ready in reset", 16'h0000, {15'h0000, req_ready});
        chk_w("select in reset", 16'h0000, {15'h0000, sel});
        rst_n = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk_n("boot wait", SHORT, SHORT + 3, n);
        $display("test boot done");
    endtask
    task automatic t_rw();
        s0 = hs_cyc;
        do_op(NVH_OP_WRITE, 4'h5, 16'h1234, 2'b11, 100);
        do_op(NVH_OP_WRITE, 4'h5, 16'hab00, 2'b10, 100);
        w0 = wr_cyc;
        do_op(NVH_OP_READ, 4'h5, 16'h0000, 2'b11, 100);
        chk_n("read latency", ACE_FAST_CYC + 2, ACE_FAST_CYC + 2, n);
        chk_w("read data", 16'hab34, rsp_rdata);
        chk_n("strobe in read", 0, 0, wr_cyc - w0);
        creg = 1'b1;
        do_op(NVH_OP_WRITE, 4'h6, 16'h5678, 2'b10, 100);
        creg = 1'b0;
        do_op(NVH_OP_READ, 4'h6, 16'h0000, 2'b11, 100);
        chk_w("clock lane write", 16'h5678, rsp_rdata);
        chk_n("store line idle", 0, 0, hs_cyc - s0);
        $display("test read write done");
    endtask
    task automatic t_soft();
        s0 = sel_cnt;
        w0 = wr_cyc;
        do_op(NVH_OP_SOFT, 4'h0, 16'h0000, 2'b11, 60000);
        chk_n("soft selects", CMD_LEN, CMD_LEN, sel_cnt - s0);
        chk_w("soft order low", 16'habcd, alog[15:0]);
        chk_w("soft order high", 16'h0089, {8'h00, alog[23:16]});
        chk_n("soft strobe", 0, 0, wr_cyc - w0);
        chk_n("soft wait", SHORT + SOFT_LO, SHORT + SOFT_HI, n);
        lw = 1'b0;
        do_op(NVH_OP_SOFT, 4'h0, 16'h0000, 2'b11, 60000);
        lw = 1'b1;
        chk_n("soft only", SS_CYC + SOFT_LO, SS_CYC + SOFT_HI, n);
        $display("test soft done");
    endtask
    task automatic t_store();
        s0 = hs_cyc;
        w0 = rdy_lo;
        do_op(NVH_OP_HWSTORE, 4'h0, 16'h0000, 2'b11, 2000);
        chk_n("ready while busy", PHSB_CYC + SHORT, 2000, rdy_lo - w0);
        chk_n("store pulse", PHSB_CYC, 2000, hs_cyc - s0);
        do_op(NVH_OP_READ, 4'h5, 16'h0000, 2'b11, 100);
        chk_w("read after store", 16'hab34, rsp_rdata);
        $display("test store done");
    endtask
    task automatic t_sleep();
        do_op(NVH_OP_SLEEP, 4'h0, 16'h0000, 2'b11, 0);
        repeat (SHORT + 10) @(negedge clk);
        chk_w("sleep line", 16'h0000, {15'h0000, sln});
        chk_w("ready asleep", 16'h0000, {15'h0000, req_ready});
        do_op(NVH_OP_WAKE, 4'h0, 16'h0000, 2'b11, 200);
        chk_n("wake wait", SHORT, 199, n);
        chk_w("sleep released", 16'h0001, {15'h0000, sln});
        $display("test sleep done");
    endtask
    task automatic end_sim();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        t_boot();
        t_rw();
        t_soft();
        t_store();
        t_sleep();
        end_sim();
    end
endmodule
